//--- test/rocfg_bank_chk.sv
// Assertion checker for the option configuration bank.
// Assumes it watches only the bank's top-level ports, so it is bound to every bank instance.
`timescale 1ns/1ns
module rocfg_bank_chk (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       sync_mode_pin_i,
    input wire logic       sync_clock_detected_i,
    input wire logic [3:0] shortcircuit_fault_i,
    input wire logic [3:0] overvoltage_fault_i,
    input wire logic       fuse_discharge_i,
    input wire logic       fuse_shortcircuit_i,
    input wire logic       fuse_overvoltage_i,
    input wire logic       fuse_ch1_half_rate_i,
    input wire logic       fuse_ch3_half_rate_i,
    input wire logic [3:0] auto_powersave_active_o,
    input wire logic [3:0] output_discharge_enable_o,
    input wire logic [3:0] shortcircuit_latchoff_enable_o,
    input wire logic [3:0] overvoltage_latchoff_enable_o,
    input wire logic       ch1_half_rate_select_o,
    input wire logic       ch3_half_rate_select_o,
    input wire logic [1:0] ch2_phase_offset_o,
    input wire logic [1:0] ch3_phase_offset_o,
    input wire logic [1:0] ch4_phase_offset_o,
    input wire logic       sync_output_select_o,
    input wire logic [3:0] channel_latched_flag_o
);
    logic [3:0] c1, c2, c3, c4;
    wire  [3:0] sc_en = shortcircuit_fault_i & shortcircuit_latchoff_enable_o;
    wire  [3:0] ov_en = overvoltage_fault_i & overvoltage_latchoff_enable_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Enabled faults seen over the last few cycles
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            {c1, c2, c3, c4} <= 16'h0;
        else
            {c1, c2, c3, c4} <= {sc_en | ov_en, c1, c2, c3};
    a_reset_values: assert property (disable iff (1'b0) rst_i |-> ch2_phase_offset_o == 2'h2 &&
        ch3_phase_offset_o == 2'h0 && ch4_phase_offset_o == 2'h2 && !sync_output_select_o)
        else $error("reset values wrong");
    a_fuse_load: assert property ($past(rst_i) |=> output_discharge_enable_o == {4{fuse_discharge_i}} &&
        shortcircuit_latchoff_enable_o == {4{fuse_shortcircuit_i}} && overvoltage_latchoff_enable_o ==
        {4{fuse_overvoltage_i}} && ch1_half_rate_select_o == fuse_ch1_half_rate_i &&
        ch3_half_rate_select_o == fuse_ch3_half_rate_i) else $error("fuse values not loaded");
    a_mode_forced_auto: assert property ((!sync_mode_pin_i && !sync_output_select_o &&
        !sync_clock_detected_i) [*5] |=> auto_powersave_active_o == 4'hF) else $error("mode not forced");
    a_scp_flag_set: assert property ($stable(sc_en) [*4] |-> (sc_en & ~channel_latched_flag_o) == 4'h0)
        else $error("short-circuit flag missing");
    a_ovp_flag_set: assert property ($stable(ov_en) [*4] |-> (ov_en & ~channel_latched_flag_o) == 4'h0)
        else $error("overvoltage flag missing");
    a_flag_has_cause: assert property ((channel_latched_flag_o & ~$past(channel_latched_flag_o) &
        ~(c1 | c2 | c3 | c4)) == 4'h0) else $error("flag set without enabled fault");
    a_sda_open_drain: assert property (sda_o == 1'b0) else $error("data pin driven high");
    a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data changed with clock high");
    c_flag: cover property (channel_latched_flag_o != 4'h0);
    c_ack: cover property ($rose(sda_oe_o));
    c_sync_out: cover property (sync_output_select_o);
endmodule

bind rocfg_bank rocfg_bank_chk u_chk (.*);

//--- test/rocfg_bank_tb.sv
// Self-checking bench of the option bank, driven over its two-wire serial port.
// Assumes the bank's defines header and the checker are compiled alongside.
`timescale 1ns/1ns
`include "rocfg_defs.vh"
module rocfg_bank_tb;
    logic        clk_i = 0, rst_i = 0, scl = 1, msda = 1, pin = 0, det = 0, k;
    logic [3:0]  sc = 0, ov = 0;
    logic [4:0]  fz = 0;
    logic [7:0]  r, x, p, d;
    logic [31:0] seed = 32'hC088;
    int          mismatches = 0;
    int          cmp_count = 0;
    wire         sda_oe, so, h1, h3;
    wire  [3:0]  auto_ps, dscg, sce, ove, flag;
    wire  [1:0]  ph2, ph3, ph4;
    wire         sda = msda & ~sda_oe;
    rocfg_bank uut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .sync_mode_pin_i(pin), .sync_clock_detected_i(det), .shortcircuit_fault_i(sc),
        .overvoltage_fault_i(ov), .fuse_discharge_i(fz[0]), .fuse_shortcircuit_i(fz[1]),
        .fuse_overvoltage_i(fz[2]), .fuse_ch1_half_rate_i(fz[3]), .fuse_ch3_half_rate_i(fz[4]),
        .auto_powersave_active_o(auto_ps), .output_discharge_enable_o(dscg),
        .shortcircuit_latchoff_enable_o(sce), .overvoltage_latchoff_enable_o(ove),
        .ch1_half_rate_select_o(h1), .ch3_half_rate_select_o(h3), .ch2_phase_offset_o(ph2),
        .ch3_phase_offset_o(ph3), .ch4_phase_offset_o(ph4), .sync_output_select_o(so),
        .channel_latched_flag_o(flag));
    always #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Register contents as seen on the configuration pins
    function automatic logic [7:0] img(input logic [7:0] a);
        if (a == 8'h06)
            return {dscg, 4'h0};
        if (a == 8'h07)
            return {ove, sce};
        return {h3, h1, ph4, ph3, ph2};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic bitx(input logic b, output logic q);
        msda = b;
        cyc(8);
        scl = 1;
        cyc(4);
        q = sda;
        cyc(4);
        scl = 0;
        cyc(2);
    endtask
    task automatic xb(input logic [7:0] v, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            bitx(v[i], q[i]);
        bitx(1'b1, a);
    endtask
    task automatic sta;
        msda = 1;
        cyc(4);
        scl = 1;
        cyc(8);
        msda = 0;
        cyc(8);
        scl = 0;
        cyc(2);
    endtask
    task automatic sto;
        msda = 0;
        cyc(4);
        scl = 1;
        cyc(8);
        msda = 1;
        cyc(8);
    endtask
    task automatic head(input logic [7:0] a);
        sta;
        xb({`ROCFG_SLAVE_ADDR, 1'b0}, r, k);
        check(k, 0);
        xb(a, r, k);
        check(k, 0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        head(a);
        xb(v, r, k);
        check(k, 0);
        sto;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        head(a);
        sta;
        xb({`ROCFG_SLAVE_ADDR, 1'b1}, r, k);
        check(k, 0);
        xb(8'hFF, q, k);
        sto;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        print_verdict;
    end
    initial
    begin
        #1;
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            fz = (i == 0) ? 5'h1F : (i == 1) ? 5'h00 : seed[4:0];
            rst_i = 1;
            cyc(5);
            rst_i = 0;
            cyc(2);
            rd(8'h06, x);
            check(x, {{4{fz[0]}}, 4'h0});
            rd(8'h07, x);
            check(x, {{4{fz[2]}}, {4{fz[1]}}});
            rd(8'h08, x);
            check(x, {fz[4], fz[3], 6'h22});
            rd(8'h0A, x);
            check(x, 8'h00);
        end
        $display("test reset values done");
        for (int i = 0; i < 9; i++)
        begin
            seed = lfsr(seed);
            p = 8'h06 + i % 3;
            d = (i < 3) ? 8'hFF : seed[15:8];
            wr(p, d);
            rd(p, x);
            check(x, d);
            check(img(p), p == 8'h06 ? {d[7:4], 4'h0} : d);
        end
        $display("test read back done");
        seed = lfsr(seed);
        d = {4'h0, seed[3:1], ~seed[3]};
        wr(8'h06, d);
        for (int j = 0; j < 4; j++)
        begin
            pin = (j == 1);
            det = (j == 2);
            wr(8'h0A, j == 3 ? 8'h80 : 8'h00);
            cyc(6);
            check(auto_ps, j == 0 ? 4'hF : d[3:0]);
            check(so, j == 3);
        end
        $display("test mode select done");
        wr(8'h07, 8'h21);
        sc = 4'hF;
        ov = 4'hF;
        cyc(6);
        check(flag, 4'h3);
        ov = 0;
        wr(8'h0C, 8'h03);
        rd(8'h0C, x);
        check(x & 8'h0F, 8'h01);
        sc = 0;
        wr(8'h0C, 8'h01);
        check(flag, 4'h0);
        $display("test latch flags done");
        sta;
        xb({`ROCFG_SLAVE_ADDR ^ 7'h01, 1'b0}, r, k);
        check(k, 1);
        sto;
        rd(8'h20, x);
        check(x, 8'h00);
        $display("test refusals done");
        print_verdict;
    end
endmodule

//--- verilog/rocfg_bank.v
// Option configuration bank of a quad buck controller behind a two-wire serial port.
// Assumes fuse straps are stable at reset release and fault inputs are asynchronous levels.
`timescale 1ns/1ns
`include "rocfg_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Power-save selection applies while mode pin high or pin configured for clocking.
// - Mode pin low and not clocking forces all channels to automatic power-save.
// - Register 0x06 bits 0..3 select channel mode, 0 forced PWM at reset.
// - Register 0x06 bits 4..7 enable output discharge per channel.
// - All four discharge enables load together from one fuse at reset.
// - Register 0x07 bits 4..7 enable overvoltage latch-off per channel.
// - Register 0x07 bits 0..3 enable short-circuit latch-off per channel.
// - Enabled latch-off error sets that channel's latched flag in register 12.
// - Short-circuit and overvoltage enables load from their fuses, same for all channels.
// - Register 0x08 bit 6 and bit 7 halve channel 1 and channel 3 rate.
// - Both half-rate bits load their reset values from fuses.
// - Register 0x08 holds phase offsets: ch4 bits 5:4, ch3 3:2, ch2 1:0.
// - Phase codes 0/90/180/270 degrees; reset ch2 and ch4 180, ch3 0.
// - A separate bit selects mode pin as sync input (0, reset) or output.
module rocfg_bank (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output reg        sda_oe_o,
    input  wire       sync_mode_pin_i,
    input  wire       sync_clock_detected_i,
    input  wire [3:0] shortcircuit_fault_i,
    input  wire [3:0] overvoltage_fault_i,
    input  wire       fuse_discharge_i,
    input  wire       fuse_shortcircuit_i,
    input  wire       fuse_overvoltage_i,
    input  wire       fuse_ch1_half_rate_i,
    input  wire       fuse_ch3_half_rate_i,
    output reg  [3:0] auto_powersave_active_o,
    output wire [3:0] output_discharge_enable_o,
    output wire [3:0] shortcircuit_latchoff_enable_o,
    output wire [3:0] overvoltage_latchoff_enable_o,
    output wire       ch1_half_rate_select_o,
    output wire       ch3_half_rate_select_o,
    output wire [1:0] ch2_phase_offset_o,
    output wire [1:0] ch3_phase_offset_o,
    output wire [1:0] ch4_phase_offset_o,
    output wire       sync_output_select_o,
    output wire [3:0] channel_latched_flag_o
);

localparam ST_IDLE   = 4'h0;
localparam ST_ADDR   = 4'h1;
localparam ST_ACK_AD = 4'h2;
localparam ST_REG    = 4'h3;
localparam ST_ACK_RG = 4'h4;
localparam ST_WDATA  = 4'h5;
localparam ST_ACK_WR = 4'h6;
localparam ST_RDATA  = 4'h7;
localparam ST_ACK_RD = 4'h8;

reg  [7:0]  mode_discharge_config;
reg  [7:0]  latchoff_config;
reg  [7:0]  switching_phase_config;
reg         sync_output_select;
reg  [3:0]  channel_latched_flag;
reg         fuse_loaded;

reg  [3:0]  state;
reg  [3:0]  bit_cnt;
reg  [7:0]  rx_shift;
reg  [7:0]  tx_shift;
reg  [7:0]  pointer;
reg         read_dir;
reg         master_nack;
reg         scl_prev;
reg         sda_prev;

wire [10:0] synced;
wire        scl_s;
wire        sda_s;
wire        mode_pin_s;
wire [3:0]  scp_s;
wire [3:0]  ovp_s;

////////////////////////////////////////////////////////////////////////////////
// Synchronisers for pins and fault levels; serial lines idle high

rocfg_sync #(
    .WIDTH   (11),
    .RST_VAL (11'h600)
) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({scl_i, sda_i, sync_mode_pin_i, shortcircuit_fault_i, overvoltage_fault_i}),
    .sync_o  (synced)
);

assign scl_s      = synced[10];
assign sda_s      = synced[9];
assign mode_pin_s = synced[8];
assign scp_s      = synced[7:4];
assign ovp_s      = synced[3:0];

////////////////////////////////////////////////////////////////////////////////
// Register read decode

function [7:0] reg_read;
    input [7:0] addr;
    begin
        case (addr)
            `ROCFG_ADDR_MODE_DSCG: reg_read = mode_discharge_config;
            `ROCFG_ADDR_LATCHOFF:  reg_read = latchoff_config;
            `ROCFG_ADDR_SW_PHASE:  reg_read = switching_phase_config;
            `ROCFG_ADDR_SYNC_CFG:  reg_read = {sync_output_select, 7'h00};
            `ROCFG_ADDR_STATUS:    reg_read = {4'h0, channel_latched_flag};
            default:               reg_read = 8'h00;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Serial slave: start/stop detection and byte engine

wire scl_rise = scl_s & ~scl_prev;
wire scl_fall = ~scl_s & scl_prev;
wire start_c  = scl_s & scl_prev & sda_prev & ~sda_s;
wire stop_c   = scl_s & scl_prev & ~sda_prev & sda_s;
wire wr_byte  = (state == ST_WDATA) & scl_fall & (bit_cnt == 4'h8);

assign sda_o = 1'b0;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        state       <= ST_IDLE;
        bit_cnt     <= 4'h0;
        rx_shift    <= 8'h00;
        tx_shift    <= 8'h00;
        pointer     <= 8'h00;
        read_dir    <= 1'b0;
        master_nack <= 1'b0;
        sda_oe_o    <= 1'b0;
        scl_prev    <= 1'b1;
        sda_prev    <= 1'b1;
    end
    else
    begin
        scl_prev <= scl_s;
        sda_prev <= sda_s;
        if (start_c)
        begin
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            sda_oe_o <= 1'b0;
        end
        else if (stop_c)
        begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (state)
                ST_ADDR, ST_REG, ST_WDATA:
                begin
                    rx_shift <= {rx_shift[6:0], sda_s};
                    bit_cnt  <= bit_cnt + 4'h1;
                end
                ST_RDATA:  bit_cnt     <= bit_cnt + 4'h1;
                ST_ACK_RD: master_nack <= sda_s;
                default:   bit_cnt     <= bit_cnt;
            endcase
        end
        else if (scl_fall)
        begin
            case (state)
                ST_ADDR:
                    if (bit_cnt == 4'h8)
                    begin
                        if (rx_shift[7:1] == `ROCFG_SLAVE_ADDR)
                        begin
                            read_dir <= rx_shift[0];
                            sda_oe_o <= 1'b1;
                            state    <= ST_ACK_AD;
                        end
                        else
                            state <= ST_IDLE;
                    end
                ST_ACK_AD:
                begin
                    bit_cnt <= 4'h0;
                    if (read_dir)
                    begin
                        tx_shift <= reg_read(pointer);
                        sda_oe_o <= ~|(reg_read(pointer) & 8'h80);
                        state    <= ST_RDATA;
                    end
                    else
                    begin
                        sda_oe_o <= 1'b0;
                        state    <= ST_REG;
                    end
                end
                ST_REG:
                    if (bit_cnt == 4'h8)
                    begin
                        pointer  <= rx_shift;
                        sda_oe_o <= 1'b1;
                        state    <= ST_ACK_RG;
                    end
                ST_ACK_RG, ST_ACK_WR:
                begin
                    sda_oe_o <= 1'b0;
                    bit_cnt  <= 4'h0;
                    state    <= ST_WDATA;
                end
                ST_WDATA:
                    if (bit_cnt == 4'h8)
                    begin
                        pointer  <= pointer + 8'h01;
                        sda_oe_o <= 1'b1;
                        state    <= ST_ACK_WR;
                    end
                ST_RDATA:
                    if (bit_cnt == 4'h8)
                    begin
                        pointer  <= pointer + 8'h01;
                        sda_oe_o <= 1'b0;
                        state    <= ST_ACK_RD;
                    end
                    else
                    begin
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        sda_oe_o <= ~tx_shift[6];
                    end
                ST_ACK_RD:
                begin
                    bit_cnt <= 4'h0;
                    if (master_nack)
                        state <= ST_IDLE;
                    else
                    begin
                        tx_shift <= reg_read(pointer);
                        sda_oe_o <= ~|(reg_read(pointer) & 8'h80);
                        state    <= ST_RDATA;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers; fuse defaults caught on the first edge after reset

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        fuse_loaded            <= 1'b0;
        mode_discharge_config  <= 8'h00;
        latchoff_config        <= 8'h00;
        switching_phase_config <= {2'b00, `ROCFG_RST_PH4, `ROCFG_RST_PH3, `ROCFG_RST_PH2};
        sync_output_select     <= `ROCFG_RST_SYNC_OUT;
    end
    else if (!fuse_loaded)
    begin
        fuse_loaded <= 1'b1;
        mode_discharge_config  <= {{4{fuse_discharge_i}}, `ROCFG_RST_PSM};
        latchoff_config        <= {{4{fuse_overvoltage_i}}, {4{fuse_shortcircuit_i}}};
        switching_phase_config[`ROCFG_CH1_HALF_RATE_SELECT_BIT] <= fuse_ch1_half_rate_i;
        switching_phase_config[`ROCFG_CH3_HALF_RATE_SELECT_BIT] <= fuse_ch3_half_rate_i;
    end
    else if (wr_byte)
    begin
        case (pointer)
            `ROCFG_ADDR_MODE_DSCG: mode_discharge_config  <= rx_shift;
            `ROCFG_ADDR_LATCHOFF:  latchoff_config        <= rx_shift;
            `ROCFG_ADDR_SW_PHASE:  switching_phase_config <= rx_shift;
            `ROCFG_ADDR_SYNC_CFG:  sync_output_select     <= rx_shift[`ROCFG_SYNC_OUT_BIT];
            default:               sync_output_select     <= sync_output_select;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Latched-off flags: set by enabled faults, write one to clear, set wins

wire status_wr = wr_byte & (pointer == `ROCFG_ADDR_STATUS);

wire [3:0]  trip;
wire [3:0]  next_latched_flag;

genvar ch;
generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_latch
        assign trip[ch] = (latchoff_config[`ROCFG_SCP_LSB + ch] & scp_s[ch])
                        | (latchoff_config[`ROCFG_OVP_LSB + ch] & ovp_s[ch]);
    end
endgenerate

assign next_latched_flag = trip | (channel_latched_flag & ~({4{status_wr}} & rx_shift[3:0]));

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
        channel_latched_flag <= 4'h0;
    else
        channel_latched_flag <= next_latched_flag;
end

////////////////////////////////////////////////////////////////////////////////
// Effective channel mode from the mode pin and clocking configuration

wire pin_clocking = sync_output_select | sync_clock_detected_i;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
        auto_powersave_active_o <= 4'hF;
    else if (mode_pin_s | pin_clocking)
        auto_powersave_active_o <= mode_discharge_config[`ROCFG_PSM_LSB +: 4];
    else
        auto_powersave_active_o <= 4'hF;
end

assign output_discharge_enable_o      = mode_discharge_config[`ROCFG_DSCG_LSB +: 4];
assign shortcircuit_latchoff_enable_o = latchoff_config[`ROCFG_SCP_LSB +: 4];
assign overvoltage_latchoff_enable_o  = latchoff_config[`ROCFG_OVP_LSB +: 4];
assign ch1_half_rate_select_o         = switching_phase_config[`ROCFG_CH1_HALF_RATE_SELECT_BIT];
assign ch3_half_rate_select_o         = switching_phase_config[`ROCFG_CH3_HALF_RATE_SELECT_BIT];
assign ch2_phase_offset_o             = switching_phase_config[`ROCFG_PH2_LSB +: 2];
assign ch3_phase_offset_o             = switching_phase_config[`ROCFG_PH3_LSB +: 2];
assign ch4_phase_offset_o             = switching_phase_config[`ROCFG_PH4_LSB +: 2];
assign sync_output_select_o           = sync_output_select;
assign channel_latched_flag_o         = channel_latched_flag;

endmodule

//--- verilog/rocfg_defs.vh
// Constants of the regulator option configuration bank: offsets, fields, resets.
// Assumes inclusion by bare name from the bank and its bench.
`ifndef ROCFG_DEFS_VH
`define ROCFG_DEFS_VH

// Register offsets on the serial management port
`define ROCFG_ADDR_MODE_DSCG    8'h06
`define ROCFG_ADDR_LATCHOFF     8'h07
`define ROCFG_ADDR_SW_PHASE     8'h08
`define ROCFG_ADDR_SYNC_CFG     8'h0A
`define ROCFG_ADDR_STATUS       8'h0C

// Field positions
`define ROCFG_PSM_LSB           0
`define ROCFG_DSCG_LSB          4
`define ROCFG_SCP_LSB           0
`define ROCFG_OVP_LSB           4
`define ROCFG_PH2_LSB           0
`define ROCFG_PH3_LSB           2
`define ROCFG_PH4_LSB           4
`define ROCFG_CH1_HALF_RATE_SELECT_BIT         6
`define ROCFG_CH3_HALF_RATE_SELECT_BIT         7
`define ROCFG_SYNC_OUT_BIT      7

// Reset values of the non-fuse fields
`define ROCFG_RST_PSM           4'h0
`define ROCFG_RST_PH2           2'h2
`define ROCFG_RST_PH3           2'h0
`define ROCFG_RST_PH4           2'h2
`define ROCFG_RST_SYNC_OUT      1'b0

// Serial port slave address, arbitrary value
`define ROCFG_SLAVE_ADDR        7'h48

`endif

//--- verilog/rocfg_sync.v
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level; the output is the second flop only.
`timescale 1ns/1ns

module rocfg_sync #(
    parameter             WIDTH   = 11,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        meta   <= RST_VAL;
        sync_o <= RST_VAL;
    end
    else
    begin
        meta   <= async_i;
        sync_o <= meta;
    end
end

endmodule
